/* core/pcrb_bank.v */
// Command decode and configuration store of the power bus target.
// Assumes framing (address, PEC, group command) is done upstream and each
// command arrives as one decoded request with its kind and data.
`timescale 1ns/1ps
`include "pcrb_consts.vh"

//Contract
// R01: Send-byte 03h clears every latched fault status bit.
// R02: Send-byte 15h copies current user configuration into the OTP store.
// R03: Send-byte 16h reloads user configuration from the OTP store.
// R04: Read-byte 19h returns a value with upper nibble 1011.
// R05: Byte 01h turns conversion on/off and selects nominal or margins.
// R06: Byte 02h selects which of enable pin and command start the unit.
// R07: Byte 10h decides which other bus writes are accepted.
// R08: Word 1Bh mask, written by word, read by process call, gates alert.
// R09: Word 21h sets output target, default 1 V.
// R10: Word 22h trims the output target, default zero.
// R11: Word 24h clamps the effective target, default 2 V.
// R12: Words 25h/26h are margin targets used when margining is selected.
// R13: Word 27h slew rate, default 0.0625 mV/us, exponents 0 to -4.
// R14: Word 29h loop scale, only 1, 0.5, 0.25, 0.125 at exponent -3.
// R15: Word 33h switching frequency 504 to 1500 kHz, default 978.
// R16: Word 35h start threshold, 0.5 V steps, default 8.0 V.
// R17: Word 36h stop threshold, 0.5 V steps, default 7.0 V.
// R18: Word 39h current offset, 0.25 A steps, default 0 A.
// R19: Word 40h over-voltage fault level, default 2.102 V.
// R20: Byte 41h over-voltage response, 00h ignore, 80h shut down.
// R21: Words 42h/43h high and low warning levels, 3.9 mV steps.
// R22: Low warning raised when sensed output drops below 43h level; the code raises it only while running_reg is set.
// R23: Fault clear accepted as send-byte with or without PEC.
// R24: Group command writes are accepted like ordinary writes.
// R25: Linear words with disallowed exponent are rejected and flagged.
// R26: Reads of unsupported codes return no data and flag a fault.
module pcrb_bank (
  input wire clk_i, // 100 MHz clock
  input wire rst_i, // Synchronous reset, active high
  input wire ce_i, // Clock enable, freezes all state when low
  input wire req_i, // One-cycle command strobe
  input wire [7:0] code_i, // Command code
  input wire [2:0] kind_i, // Transaction kind
  input wire [15:0] wdata_i, // Write data, bytes in low half
  input wire en_pin_i, // Enable pin level
  input wire [10:0] vin_i, // Input voltage, 0.5 V per count
  input wire [15:0] ovp_sense_i, // Output sense, over-voltage fault units
  input wire [15:0] vsense_i, // Output sense, 3.9 mV per count
  output reg rd_valid_o, // Read answer strobe
  output reg rd_err_o, // Read refused, with rd_valid_o
  output reg [15:0] rd_data_o, // Read data
  output reg otp_burn_o, // Pulse while the OTP store is written
  output reg conv_on_o, // Power conversion enabled
  output reg [15:0] target_o, // Effective output target
  output reg [6:0] status_o, // Latched fault and warning bits
  output reg alert_o // Unmasked status present
);

  localparam ST_IDLE = 2'b01;
  localparam ST_EXEC = 2'b10;

  reg [15:0] cfg_reg [0:`PCRB_NREG-1];
  reg [15:0] otp_reg [0:`PCRB_NREG-1];
  reg [1:0] state_reg;
  reg [7:0] code_reg;
  reg [2:0] kind_reg;
  reg [15:0] wdata_reg;
  reg running_reg;
  reg vin_ok_reg;
  reg ov_trip_reg;
  reg [6:0] stat_next;
  reg [16:0] sum_next;
  reg [15:0] tgt_next;
  reg on_next;
  integer i;

  function [4:0] idx_of;
    input [7:0] code;
    begin
      case (code)
        `PCRB_C_RUN: idx_of = `PCRB_I_RUN;
        `PCRB_C_SRC: idx_of = `PCRB_I_SRC;
        `PCRB_C_LOCK: idx_of = `PCRB_I_LOCK;
        `PCRB_C_MASK: idx_of = `PCRB_I_MASK;
        `PCRB_C_TGT: idx_of = `PCRB_I_TGT;
        `PCRB_C_TRIM: idx_of = `PCRB_I_TRIM;
        `PCRB_C_CEIL: idx_of = `PCRB_I_CEIL;
        `PCRB_C_MHI: idx_of = `PCRB_I_MHI;
        `PCRB_C_MLO: idx_of = `PCRB_I_MLO;
        `PCRB_C_SLEW: idx_of = `PCRB_I_SLEW;
        `PCRB_C_SCALE: idx_of = `PCRB_I_SCALE;
        `PCRB_C_FREQ: idx_of = `PCRB_I_FREQ;
        `PCRB_C_VON: idx_of = `PCRB_I_VON;
        `PCRB_C_VOFF: idx_of = `PCRB_I_VOFF;
        `PCRB_C_ICAL: idx_of = `PCRB_I_ICAL;
        `PCRB_C_OVF: idx_of = `PCRB_I_OVF;
        `PCRB_C_OVA: idx_of = `PCRB_I_OVA;
        `PCRB_C_OVW: idx_of = `PCRB_I_OVW;
        `PCRB_C_UVW: idx_of = `PCRB_I_UVW;
        `PCRB_C_UVF: idx_of = `PCRB_I_UVF;
        default: idx_of = `PCRB_I_NONE;
      endcase
    end
  endfunction

  function [15:0] def_of;
    input [4:0] idx;
    begin
      case (idx)
        `PCRB_I_RUN: def_of = `PCRB_D_RUN;
        `PCRB_I_SRC: def_of = `PCRB_D_SRC;
        `PCRB_I_LOCK: def_of = `PCRB_D_LOCK;
        `PCRB_I_MASK: def_of = `PCRB_D_MASK;
        `PCRB_I_TGT: def_of = `PCRB_D_TGT;
        `PCRB_I_TRIM: def_of = `PCRB_D_TRIM;
        `PCRB_I_CEIL: def_of = `PCRB_D_CEIL;
        `PCRB_I_MHI: def_of = `PCRB_D_MHI;
        `PCRB_I_MLO: def_of = `PCRB_D_MLO;
        `PCRB_I_SLEW: def_of = `PCRB_D_SLEW;
        `PCRB_I_SCALE: def_of = `PCRB_D_SCALE;
        `PCRB_I_FREQ: def_of = `PCRB_D_FREQ;
        `PCRB_I_VON: def_of = `PCRB_D_VON;
        `PCRB_I_VOFF: def_of = `PCRB_D_VOFF;
        `PCRB_I_ICAL: def_of = `PCRB_D_ICAL;
        `PCRB_I_OVF: def_of = `PCRB_D_OVF;
        `PCRB_I_OVA: def_of = `PCRB_D_OVA;
        `PCRB_I_OVW: def_of = `PCRB_D_OVW;
        `PCRB_I_UVW: def_of = `PCRB_D_UVW;
        `PCRB_I_UVF: def_of = `PCRB_D_UVF;
        default: def_of = 16'h0000;
      endcase
    end
  endfunction

  // Byte-sized entries; everything else stored is a word
  function is_byte;
    input [4:0] idx;
    begin
      is_byte = (idx == `PCRB_I_RUN) || (idx == `PCRB_I_SRC) ||
        (idx == `PCRB_I_LOCK) || (idx == `PCRB_I_OVA);
    end
  endfunction

  // R25 exponent check on linear words
  function data_ok;
    input [4:0] idx;
    input [15:0] d;
    reg [4:0] ex;
    reg [10:0] mt;
    begin
      ex = d[15:11];
      mt = d[10:0];
      case (idx)
        // R13 exponents 0..-4
        `PCRB_I_SLEW: data_ok = (ex == `PCRB_EXP_0) ||
          (ex >= `PCRB_EXP_M4);
        // R14 scale values
        `PCRB_I_SCALE: data_ok = (ex == `PCRB_EXP_M3) &&
          ((mt == 11'd1) || (mt == 11'd2) || (mt == 11'd4) ||
           (mt == 11'd8));
        // R15 frequency range
        `PCRB_I_FREQ: data_ok = ((ex == `PCRB_EXP_0) &&
          (mt >= `PCRB_FREQ_MIN) && (mt <= `PCRB_FREQ_MAX)) ||
          ((ex == `PCRB_EXP_1) && ({mt[9:0], 1'b0} >= `PCRB_FREQ_MIN) &&
          ({mt[9:0], 1'b0} <= `PCRB_FREQ_MAX) && !mt[10]);
        // R16 R17 half-volt steps
        `PCRB_I_VON, `PCRB_I_VOFF: data_ok = (ex == `PCRB_EXP_M1);
        // R18 quarter-amp steps
        `PCRB_I_ICAL: data_ok = (ex == `PCRB_EXP_M2);
        default: data_ok = 1'b1;
      endcase
    end
  endfunction

  // R07 write lock levels
  function lock_ok;
    input [7:0] lock;
    input [7:0] code;
    begin
      if (code == `PCRB_C_LOCK) begin
        lock_ok = 1'b1;
      end else if (lock[7]) begin
        lock_ok = 1'b0;
      end else if (lock[6]) begin
        lock_ok = (code == `PCRB_C_RUN);
      end else if (lock[5]) begin
        lock_ok = (code == `PCRB_C_RUN) || (code == `PCRB_C_SRC) ||
          (code == `PCRB_C_TGT);
      end else begin
        lock_ok = 1'b1;
      end
    end
  endfunction

  wire [4:0] cur_idx = idx_of(code_reg);
  wire cur_known = (cur_idx != `PCRB_I_NONE);
  wire [7:0] run_b = cfg_reg[`PCRB_I_RUN][7:0];
  wire [7:0] src_b = cfg_reg[`PCRB_I_SRC][7:0];
  wire is_write = (kind_reg == `PCRB_K_WRB) || (kind_reg == `PCRB_K_WRW);
  wire is_read = (kind_reg == `PCRB_K_RDB) || (kind_reg == `PCRB_K_RDW) ||
    (kind_reg == `PCRB_K_PCALL);
  wire kind_fit = cur_known && (is_byte(cur_idx) ?
    (kind_reg == `PCRB_K_WRB) : (kind_reg == `PCRB_K_WRW));
  // R08 mask is read only through the process call
  wire read_fit = (code_reg == `PCRB_C_FEAT) ?
    (kind_reg == `PCRB_K_RDB) :
    (cur_idx == `PCRB_I_MASK) ? (kind_reg == `PCRB_K_PCALL) :
    (cur_known && (is_byte(cur_idx) ? (kind_reg == `PCRB_K_RDB) :
    (kind_reg == `PCRB_K_RDW)));
  wire wr_take = (state_reg == ST_EXEC) && is_write && kind_fit &&
    lock_ok(cfg_reg[`PCRB_I_LOCK][7:0], code_reg) &&
    data_ok(cur_idx, wdata_reg);
  wire exe = (state_reg == ST_EXEC);
  // R23 fault clear is a send-byte; PEC is checked upstream
  wire wipe = exe && (kind_reg == `PCRB_K_SEND) &&
    (code_reg == `PCRB_C_WIPE);
  wire store = exe && (kind_reg == `PCRB_K_SEND) &&
    (code_reg == `PCRB_C_STORE);
  wire restore = exe && (kind_reg == `PCRB_K_SEND) &&
    (code_reg == `PCRB_C_RESTORE);
  wire send_bad = exe && (kind_reg == `PCRB_K_SEND) && !wipe && !store &&
    !restore;
  wire wr_bad = exe && is_write && !wr_take;
  wire wr_badx = exe && is_write && kind_fit &&
    !data_ok(cur_idx, wdata_reg);
  wire rd_bad = exe && is_read && !read_fit;

  // Request capture: one command per two cycles, later strobes dropped
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      code_reg <= 8'h00;
      kind_reg <= 3'h0;
      wdata_reg <= 16'h0000;
    end else if (ce_i) begin
      case (state_reg)
        ST_IDLE: begin
          if (req_i) begin
            code_reg <= code_i;
            kind_reg <= kind_i;
            wdata_reg <= wdata_i;
            state_reg <= ST_EXEC;
          end
        end
        ST_EXEC: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Configuration table and its OTP copy
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (i = 0; i < `PCRB_NREG; i = i + 1) begin
        cfg_reg[i] <= def_of(i[4:0]);
        otp_reg[i] <= def_of(i[4:0]);
      end
    end else if (ce_i) begin
      if (wr_take) begin
        // R24 group writes arrive here one regulator at a time
        cfg_reg[cur_idx] <= is_byte(cur_idx) ? {8'h00, wdata_reg[7:0]} :
          wdata_reg;
      end else if (store) begin
        // R02 burn user section
        for (i = 0; i < `PCRB_NREG; i = i + 1) begin
          otp_reg[i] <= cfg_reg[i];
        end
      end else if (restore) begin
        // R03 reload user section
        for (i = 0; i < `PCRB_NREG; i = i + 1) begin
          cfg_reg[i] <= otp_reg[i];
        end
      end
    end
  end

  // Read answers
  always @(posedge clk_i) begin
    if (rst_i) begin
      rd_valid_o <= 1'b0;
      rd_err_o <= 1'b0;
      rd_data_o <= 16'h0000;
      otp_burn_o <= 1'b0;
    end else if (ce_i) begin
      rd_valid_o <= exe && is_read;
      rd_err_o <= rd_bad;
      otp_burn_o <= store;
      if (exe && is_read && read_fit) begin
        // R04 feature byte
        if (code_reg == `PCRB_C_FEAT) begin
          rd_data_o <= {8'h00, `PCRB_FEATURE};
        end else begin
          rd_data_o <= cfg_reg[cur_idx];
        end
      end else if (exe && is_read) begin
        // R26 no data for unsupported codes
        rd_data_o <= 16'h0000;
      end
    end
  end

  // Effective target: select, trim, clamp
  always @* begin
    // R12 margin select
    case (run_b[5:4])
      2'b01: tgt_next = cfg_reg[`PCRB_I_MLO];
      2'b10: tgt_next = cfg_reg[`PCRB_I_MHI];
      // R09 nominal target
      default: tgt_next = cfg_reg[`PCRB_I_TGT];
    endcase
    // R10 signed trim added
    sum_next = {1'b0, tgt_next} +
      {cfg_reg[`PCRB_I_TRIM][15], cfg_reg[`PCRB_I_TRIM]};
    // Negative trim saturates at zero when the sign-extended sum goes negative, positive trim at FFFFh
    if (cfg_reg[`PCRB_I_TRIM][15] && sum_next[16]) begin
      tgt_next = 16'h0000;
    end else if (!cfg_reg[`PCRB_I_TRIM][15] && sum_next[16]) begin
      tgt_next = 16'hFFFF;
    end else begin
      tgt_next = sum_next[15:0];
    end
    // R11 ceiling
    if (tgt_next > cfg_reg[`PCRB_I_CEIL]) begin
      tgt_next = cfg_reg[`PCRB_I_CEIL];
    end
    // R06 start source
    if (!src_b[4]) begin
      on_next = 1'b1;
    end else begin
      // R05 run bit
      on_next = (!src_b[3] || run_b[7]) &&
        (!src_b[2] || (en_pin_i == src_b[1]));
    end
  end

  // Status: set wins over the clear command
  always @* begin
    stat_next = status_o;
    // R01 clear latched faults
    if (wipe) begin
      stat_next = {`PCRB_NSTAT{1'b0}};
    end
    if (wr_bad || send_bad || rd_bad) begin
      stat_next[`PCRB_S_CML] = 1'b1;
    end
    // R25 bad exponent flag
    if (wr_badx) begin
      stat_next[`PCRB_S_BADX] = 1'b1;
    end
    // R26 unsupported code flag
    if ((exe && !cur_known && (is_read || is_write) &&
        code_reg != `PCRB_C_FEAT) || send_bad) begin
      stat_next[`PCRB_S_UNSUP] = 1'b1;
    end
    // R19 over-voltage fault
    if (ovp_sense_i > cfg_reg[`PCRB_I_OVF]) begin
      stat_next[`PCRB_S_OVF] = 1'b1;
    end
    // R21 high warning
    if (vsense_i > cfg_reg[`PCRB_I_OVW]) begin
      stat_next[`PCRB_S_OVW] = 1'b1;
    end
    // R22 low warning
    if (running_reg && (vsense_i < cfg_reg[`PCRB_I_UVW])) begin
      stat_next[`PCRB_S_UVW] = 1'b1;
    end
    if (running_reg && (vsense_i < cfg_reg[`PCRB_I_UVF])) begin
      stat_next[`PCRB_S_UVF] = 1'b1;
    end
  end

  // Conversion control and outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      running_reg <= 1'b0;
      vin_ok_reg <= 1'b0;
      ov_trip_reg <= 1'b0;
      conv_on_o <= 1'b0;
      target_o <= 16'h0000;
      status_o <= {`PCRB_NSTAT{1'b0}};
      alert_o <= 1'b0;
    end else if (ce_i) begin
      // R16 R17 input hysteresis on half-volt mantissas
      if (vin_i >= cfg_reg[`PCRB_I_VON][10:0]) begin
        vin_ok_reg <= 1'b1;
      end else if (vin_i < cfg_reg[`PCRB_I_VOFF][10:0]) begin
        vin_ok_reg <= 1'b0;
      end
      // R20 shutdown response latches until faults are wiped
      if (wipe) begin
        ov_trip_reg <= 1'b0;
      end
      if ((cfg_reg[`PCRB_I_OVA][7:0] == `PCRB_OVA_SHUT) &&
          (ovp_sense_i > cfg_reg[`PCRB_I_OVF])) begin
        ov_trip_reg <= 1'b1;
      end
      running_reg <= on_next && vin_ok_reg && !ov_trip_reg;
      conv_on_o <= on_next && vin_ok_reg && !ov_trip_reg;
      target_o <= tgt_next;
      status_o <= stat_next;
      // R08 mask gates the alert
      alert_o <= |(stat_next & ~cfg_reg[`PCRB_I_MASK][`PCRB_NSTAT-1:0]);
    end
  end

endmodule // pcrb_bank

/* core/pcrb_consts.vh */
// Command codes, table indices, reset values and field positions
// for the power bus command register bank.
// Included by the bank; holds definitions only.
`ifndef PCRB_CONSTS_VH
`define PCRB_CONSTS_VH

// Command codes
`define PCRB_C_RUN 8'h01
`define PCRB_C_SRC 8'h02
`define PCRB_C_WIPE 8'h03
`define PCRB_C_LOCK 8'h10
`define PCRB_C_STORE 8'h15
`define PCRB_C_RESTORE 8'h16
`define PCRB_C_FEAT 8'h19
`define PCRB_C_MASK 8'h1B
`define PCRB_C_TGT 8'h21
`define PCRB_C_TRIM 8'h22
`define PCRB_C_CEIL 8'h24
`define PCRB_C_MHI 8'h25
`define PCRB_C_MLO 8'h26
`define PCRB_C_SLEW 8'h27
`define PCRB_C_SCALE 8'h29
`define PCRB_C_FREQ 8'h33
`define PCRB_C_VON 8'h35
`define PCRB_C_VOFF 8'h36
`define PCRB_C_ICAL 8'h39
`define PCRB_C_OVF 8'h40
`define PCRB_C_OVA 8'h41
`define PCRB_C_OVW 8'h42
`define PCRB_C_UVW 8'h43
`define PCRB_C_UVF 8'h44

// Table indices
`define PCRB_I_RUN 5'h00
`define PCRB_I_SRC 5'h01
`define PCRB_I_LOCK 5'h02
`define PCRB_I_MASK 5'h03
`define PCRB_I_TGT 5'h04
`define PCRB_I_TRIM 5'h05
`define PCRB_I_CEIL 5'h06
`define PCRB_I_MHI 5'h07
`define PCRB_I_MLO 5'h08
`define PCRB_I_SLEW 5'h09
`define PCRB_I_SCALE 5'h0A
`define PCRB_I_FREQ 5'h0B
`define PCRB_I_VON 5'h0C
`define PCRB_I_VOFF 5'h0D
`define PCRB_I_ICAL 5'h0E
`define PCRB_I_OVF 5'h0F
`define PCRB_I_OVA 5'h10
`define PCRB_I_OVW 5'h11
`define PCRB_I_UVW 5'h12
`define PCRB_I_UVF 5'h13
`define PCRB_I_NONE 5'h1F
`define PCRB_NREG 20

// Transaction kinds
`define PCRB_K_SEND 3'h0
`define PCRB_K_WRB 3'h1
`define PCRB_K_WRW 3'h2
`define PCRB_K_RDB 3'h3
`define PCRB_K_RDW 3'h4
`define PCRB_K_PCALL 3'h5

// Reset values
`define PCRB_D_RUN 16'h0000
`define PCRB_D_SRC 16'h0000
`define PCRB_D_LOCK 16'h0000
`define PCRB_D_MASK 16'h0000
`define PCRB_D_TGT 16'h00C8
`define PCRB_D_TRIM 16'h0000
`define PCRB_D_CEIL 16'h0190
`define PCRB_D_MHI 16'h00D2
`define PCRB_D_MLO 16'h00BE
`define PCRB_D_SLEW 16'hE001
`define PCRB_D_SCALE 16'hE808
`define PCRB_D_FREQ 16'h03D2
`define PCRB_D_VON 16'hF810
`define PCRB_D_VOFF 16'hF80E
`define PCRB_D_ICAL 16'hF000
`define PCRB_D_OVF 16'h00D2
`define PCRB_D_OVA 16'h0080
`define PCRB_D_OVW 16'h01E8
`define PCRB_D_UVW 16'h00E7
`define PCRB_D_UVF 16'h00E6
`define PCRB_FEATURE 8'hB0

// Field values
`define PCRB_OVA_SHUT 8'h80
`define PCRB_LOCK_ALL 8'h80
`define PCRB_LOCK_RUN 8'h40
`define PCRB_LOCK_CFG 8'h20
`define PCRB_EXP_M4 5'h1C
`define PCRB_EXP_M3 5'h1D
`define PCRB_EXP_M2 5'h1E
`define PCRB_EXP_M1 5'h1F
`define PCRB_EXP_0 5'h00
`define PCRB_EXP_1 5'h01
`define PCRB_FREQ_MIN 11'd504
`define PCRB_FREQ_MAX 11'd1500

// Status bit positions
`define PCRB_S_CML 0
`define PCRB_S_OVF 1
`define PCRB_S_OVW 2
`define PCRB_S_UVW 3
`define PCRB_S_UVF 4
`define PCRB_S_BADX 5
`define PCRB_S_UNSUP 6
`define PCRB_NSTAT 7

`endif

/* sim/pcrb_bank_sva.sv */
// Port-level checks of the command register bank.
// Assumes one clock; a request is taken only when the bank is idle.
`timescale 1ns/1ps
`include "pcrb_consts.vh"
module pcrb_bank_sva (
  input wire clk_i, // Clock
  input wire rst_i, // Reset
  input wire ce_i, // Enable
  input wire req_i, // Strobe
  input wire [7:0] code_i, // Code
  input wire [2:0] kind_i, // Kind
  input wire [15:0] wdata_i, // Data
  input wire en_pin_i, // Pin
  input wire [10:0] vin_i, // Input level
  input wire [15:0] ovp_sense_i, // OV sense
  input wire [15:0] vsense_i, // Sense
  input wire rd_valid_o, // Answer
  input wire rd_err_o, // Refused
  input wire [15:0] rd_data_o, // Read data
  input wire otp_burn_o, // Store pulse
  input wire conv_on_o, // Running
  input wire [15:0] target_o, // Target
  input wire [6:0] status_o, // Status
  input wire alert_o // Alert
);
  reg took_reg;
  wire take;
  wire rdk;
  // A strobe right after a take is ignored, so it is no take
  assign take = req_i && ce_i && !took_reg;
  assign rdk = kind_i >= `PCRB_K_RDB && kind_i <= `PCRB_K_PCALL;
  always @(posedge clk_i) begin
    took_reg <= rst_i ? 1'b0 : (ce_i ? take : took_reg);
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);
  property p_rd_lat;
    take && rdk |-> ##2 rd_valid_o;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer late");
  property p_feat;
    take && code_i == `PCRB_C_FEAT && kind_i == `PCRB_K_RDB
      |-> ##2 rd_data_o[7:4] == 4'hB && !rd_err_o;
  endproperty
  a_feat: assert property (p_feat)
    else $error("feature report wrong");
  property p_wipe;
    take && code_i == `PCRB_C_WIPE && kind_i == `PCRB_K_SEND
      |-> ##2 status_o[0] == 1'b0 && status_o[6:5] == 2'b00;
  endproperty
  a_wipe: assert property (p_wipe)
    else $error("fault bits not cleared");
  property p_store;
    take && code_i == `PCRB_C_STORE && kind_i == `PCRB_K_SEND
      |-> ##2 otp_burn_o;
  endproperty
  a_store: assert property (p_store)
    else $error("no store pulse");
  property p_unsup;
    take && rdk && code_i > `PCRB_C_UVF
      |-> ##2 rd_err_o && rd_data_o == 16'h0000 && status_o[6];
  endproperty
  a_unsup: assert property (p_unsup)
    else $error("unknown read not refused");
  property p_mask_kind;
    take && code_i == `PCRB_C_MASK && kind_i == `PCRB_K_RDW
      |-> ##2 rd_err_o;
  endproperty
  a_mask_kind: assert property (p_mask_kind)
    else $error("mask read by word accepted");
  property p_alert;
    alert_o |-> status_o != 7'h00;
  endproperty
  a_alert: assert property (p_alert)
    else $error("alert without status");
  property p_exp;
    take && kind_i == `PCRB_K_WRW && code_i == `PCRB_C_SLEW &&
      wdata_i[15:11] == 5'h02 |-> ##2 status_o[0];
  endproperty
  a_exp: assert property (p_exp)
    else $error("bad exponent accepted");
  property p_err;
    rd_err_o |-> rd_valid_o;
  endproperty
  a_err: assert property (p_err)
    else $error("refusal without answer");
endmodule // pcrb_bank_sva
bind pcrb_bank pcrb_bank_sva chk (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .req_i(req_i), .code_i(code_i), .kind_i(kind_i),
  .wdata_i(wdata_i), .en_pin_i(en_pin_i), .vin_i(vin_i),
  .ovp_sense_i(ovp_sense_i), .vsense_i(vsense_i),
  .rd_valid_o(rd_valid_o), .rd_err_o(rd_err_o), .rd_data_o(rd_data_o),
  .otp_burn_o(otp_burn_o), .conv_on_o(conv_on_o), .target_o(target_o),
  .status_o(status_o), .alert_o(alert_o));

/* sim/pcrb_host.sv */
// Bus host stand-in issuing one decoded command per call.
// Assumes framing and checksum are already stripped upstream.
`timescale 1ns/1ps
module pcrb_host (
  input wire clk_i, // Clock
  output reg req_o, // Strobe
  output reg [7:0] code_o, // Code
  output reg [2:0] kind_o, // Kind
  output reg [15:0] wdata_o // Data
);
  initial begin
    req_o = 1'b0;
    code_o = 8'h00;
    kind_o = 3'h0;
    wdata_o = 16'h0000;
  end
  task xfer(input [7:0] c, input [2:0] k, input [15:0] d);
    begin
      @(negedge clk_i);
      req_o = 1'b1;
      code_o = c;
      kind_o = k;
      wdata_o = d;
      @(negedge clk_i);
      req_o = 1'b0;
      // Released lines flip so stale values never pass
      code_o = ~c;
      kind_o = ~k;
      wdata_o = ~d;
    end
  endtask
endmodule // pcrb_host

/* sim/tb.sv */
// Self-checking bench for the command register bank.
// Assumes the host stand-in drives commands; sensors are set here.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
  fail_count++; $display("Error %s expected %h seen %h", n, e, g); end end
module tb;
  reg clk_i;
  reg rst_i;
  reg ce_i;
  reg en_pin_i;
  reg [10:0] vin_i;
  reg [15:0] ovp_sense_i;
  reg [15:0] vsense_i;
  wire req;
  wire [7:0] code;
  wire [2:0] kind;
  wire [15:0] wdata;
  wire rd_valid_o;
  wire rd_err_o;
  wire [15:0] rd_data_o;
  wire otp_burn_o;
  wire conv_on_o;
  wire [15:0] target_o;
  wire [6:0] status_o;
  wire alert_o;
  integer fail_count;
  integer n_tests;
  integer cyc;
  integer i;
  integer j;
  reg [39:0] yc = {8'h01, 8'h02, 8'h10, 8'h41, 8'h19};
  reg [39:0] yd = {8'h00, 8'h00, 8'h00, 8'h80, 8'hB0};
  reg [119:0] cd = {8'h21, 8'h22, 8'h24, 8'h25, 8'h26, 8'h27, 8'h29,
    8'h33, 8'h35, 8'h36, 8'h39, 8'h40, 8'h42, 8'h43, 8'h44};
  reg [239:0] df = {16'h00C8, 16'h0000, 16'h0190, 16'h00D2, 16'h00BE,
    16'hE001, 16'hE808, 16'h03D2, 16'hF810, 16'hF80E, 16'hF000,
    16'h00D2, 16'h01E8, 16'h00E7, 16'h00E6};
  reg [239:0] nv = {16'h00D0, 16'h0003, 16'h0180, 16'h00DC, 16'h00B4,
    16'h0005, 16'hE801, 16'h03E8, 16'hF812, 16'hF80C, 16'hF004,
    16'h00D4, 16'h01F0, 16'h00E0, 16'h00D8};
  // Writes that must be refused, and the value that must stay
  reg [39:0] bc = {8'h27, 8'h29, 8'h33, 8'h35, 8'h39};
  reg [79:0] bv = {16'h1005, 16'hE803, 16'h01F4, 16'hF010, 16'hF800};
  reg [79:0] bk = {16'h0005, 16'hE801, 16'h03E8, 16'hF812, 16'hF004};
  pcrb_host h (.clk_i(clk_i), .req_o(req), .code_o(code), .kind_o(kind),
    .wdata_o(wdata));
  pcrb_bank uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req),
    .code_i(code), .kind_i(kind), .wdata_i(wdata), .en_pin_i(en_pin_i),
    .vin_i(vin_i), .ovp_sense_i(ovp_sense_i), .vsense_i(vsense_i),
    .rd_valid_o(rd_valid_o), .rd_err_o(rd_err_o), .rd_data_o(rd_data_o),
    .otp_burn_o(otp_burn_o), .conv_on_o(conv_on_o), .target_o(target_o),
    .status_o(status_o), .alert_o(alert_o));
  task final_report;
    begin
      if (fail_count == 0 && n_tests > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Waits past the edge where the target and run state follow
  task wr(input [7:0] c, input [2:0] k, input [15:0] d);
    begin
      h.xfer(c, k, d);
      repeat (3) @(negedge clk_i);
    end
  endtask
  task rd(input [7:0] c, input [2:0] k, input e);
    begin
      h.xfer(c, k, 16'h0000);
      j = 0;
      while (rd_valid_o !== 1'b1 && j < 4) begin
        @(negedge clk_i);
        j++;
      end
      `CHK("rd_valid", 1'b1, rd_valid_o)
      `CHK("rd_err", e, rd_err_o)
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk_i);
      cyc++;
      if (cyc == 5000) begin
        fail_count++;
        final_report;
      end
    end
  end
  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    en_pin_i = 1'b0;
    vin_i = 11'h014;
    ovp_sense_i = 16'h0010;
    vsense_i = 16'h0100;
    fail_count = 0;
    n_tests = 0;
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    for (i = 0; i < 5; i++) begin
      rd(yc[8*(4-i) +: 8], 3'h3, 1'b0);
      `CHK("byte reset", yd[8*(4-i) +: 8], rd_data_o[7:0])
    end
    rd(8'h19, 3'h4, 1'b1);
    for (i = 0; i < 15; i++) begin
      rd(cd[8*(14-i) +: 8], 3'h4, 1'b0);
      `CHK("word reset", df[16*(14-i) +: 16], rd_data_o)
      wr(cd[8*(14-i) +: 8], 3'h2, nv[16*(14-i) +: 16]);
      rd(cd[8*(14-i) +: 8], 3'h4, 1'b0);
      `CHK("word write", nv[16*(14-i) +: 16], rd_data_o)
    end
    // Only the comm fault of the refused feature word read stands
    `CHK("cml only", 7'h01, status_o)
    `CHK("trimmed", 16'h00D3, target_o)
    wr(8'h21, 3'h2, 16'h0200);
    `CHK("clamped", 16'h0180, target_o)
    wr(8'h21, 3'h2, 16'h00D0);
    wr(8'h22, 3'h2, 16'hFFFE);
    `CHK("trim down", 16'h00CE, target_o)
    wr(8'h22, 3'h2, 16'h0000);
    wr(8'h01, 3'h1, 16'h00A0);
    `CHK("margin high", 16'h00DC, target_o)
    wr(8'h01, 3'h1, 16'h0090);
    `CHK("margin low", 16'h00B4, target_o)
    wr(8'h02, 3'h1, 16'h0018);
    wr(8'h01, 3'h1, 16'h0000);
    `CHK("run off", 1'b0, conv_on_o)
    wr(8'h01, 3'h1, 16'h0080);
    `CHK("run on", 1'b1, conv_on_o)
    wr(8'h02, 3'h1, 16'h0016);
    `CHK("pin off", 1'b0, conv_on_o)
    en_pin_i = 1'b1;
    repeat (3) @(negedge clk_i);
    `CHK("pin on", 1'b1, conv_on_o)
    wr(8'h02, 3'h1, 16'h0000);
    wr(8'h1B, 3'h2, 16'h0004);
    rd(8'h1B, 3'h5, 1'b0);
    `CHK("mask", 16'h0004, rd_data_o)
    rd(8'h1B, 3'h4, 1'b1);
    wr(8'h03, 3'h0, 16'h0000);
    // Between the low warning level and the under-voltage fault level
    vsense_i = 16'h00DC;
    repeat (3) @(negedge clk_i);
    `CHK("low warn", 7'h08, status_o)
    `CHK("alert", 1'b1, alert_o)
    wr(8'h1B, 3'h2, 16'h0008);
    `CHK("masked", 1'b0, alert_o)
    vsense_i = 16'h0100;
    wr(8'h03, 3'h0, 16'h0000);
    `CHK("wiped", 7'h00, status_o)
    ovp_sense_i = 16'h0100;
    repeat (3) @(negedge clk_i);
    `CHK("ov fault", 1'b1, status_o[1])
    `CHK("ov shut", 1'b0, conv_on_o)
    ovp_sense_i = 16'h0010;
    wr(8'h41, 3'h1, 16'h0000);
    `CHK("ov held", 1'b0, conv_on_o)
    wr(8'h03, 3'h0, 16'h0000);
    repeat (2) @(negedge clk_i);
    `CHK("restart", 1'b1, conv_on_o)
    vin_i = 11'h00D;
    repeat (3) @(negedge clk_i);
    `CHK("vin hold", 1'b1, conv_on_o)
    vin_i = 11'h00B;
    repeat (3) @(negedge clk_i);
    `CHK("input_stop_threshold", 1'b0, conv_on_o)
    vin_i = 11'h011;
    repeat (3) @(negedge clk_i);
    `CHK("vin wait", 1'b0, conv_on_o)
    vin_i = 11'h014;
    repeat (3) @(negedge clk_i);
    `CHK("input_start_threshold", 1'b1, conv_on_o)
    ovp_sense_i = 16'h0100;
    repeat (3) @(negedge clk_i);
    `CHK("ov ignored", 1'b1, conv_on_o)
    ovp_sense_i = 16'h0010;
    for (i = 0; i < 5; i++) begin
      wr(8'h03, 3'h0, 16'h0000);
      wr(bc[8*(4-i) +: 8], 3'h2, bv[16*(4-i) +: 16]);
      `CHK("bad flag", 2'b11, {status_o[5], status_o[0]})
      rd(bc[8*(4-i) +: 8], 3'h4, 1'b0);
      `CHK("bad kept", bk[16*(4-i) +: 16], rd_data_o)
    end
    rd(8'h7E, 3'h3, 1'b1);
    `CHK("unsup data", 16'h0000, rd_data_o)
    `CHK("unsup flag", 1'b1, status_o[6])
    wr(8'h10, 3'h1, 16'h0080);
    wr(8'h21, 3'h2, 16'h0111);
    wr(8'h10, 3'h1, 16'h0000);
    rd(8'h21, 3'h4, 1'b0);
    `CHK("locked", 16'h00D0, rd_data_o)
    wr(8'h21, 3'h2, 16'h00C0);
    h.xfer(8'h15, 3'h0, 16'h0000);
    // The store pulse stands for the one cycle after the second edge
    repeat (1) @(negedge clk_i);
    `CHK("burn", 1'b1, otp_burn_o)
    wr(8'h21, 3'h2, 16'h00B0);
    wr(8'h16, 3'h0, 16'h0000);
    rd(8'h21, 3'h4, 1'b0);
    `CHK("restored", 16'h00C0, rd_data_o)
    final_report;
  end
endmodule // tb
